// File: design/adc_config_register_bank.sv
// configuration and status register bank with register read and write command parser
`timescale 1ns/100ps
`include "adc_regs_map.svh"

module adc_config_register_bank #(
   parameter logic [3:0] ID_CODE = 4'h3 // arbitrary value
) (
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic RX_VALID,
   input wire logic [7:0] RX_BYTE,
   input wire logic FRAME_END,
   input wire logic TX_REQ,
   input wire logic SOFT_RST,
   input wire logic CONV_READY_N,
   input wire logic [3:0] GPIO_I,
   output logic TX_VALID,
   output logic [7:0] TX_BYTE,
   output adc_regs_pkg::cfg_s CFG,
   output logic CAL_START,
   output logic [3:0] GPIO_O,
   output logic [3:0] GPIO_OE
);
   import adc_regs_pkg::*;

   // ***********************************
   // state
   // ***********************************
   parse_e state_r;
   logic is_write_r;
   logic [3:0] addr_r;
   logic [3:0] cnt_r;
   logic changed_r;
   logic boot_r;
   logic [2:0] status_r;
   logic [7:0] mux_r;
   logic [1:0] clk_rate_r;
   logic [4:0] adc_control_low_r;
   logic [7:0] data_rate_select_r;
   logic [3:0] dir_r;
   logic [3:0] dout_r;
   logic [7:0] cal_r [6];
   logic [3:0] gpio_meta_r;
   logic [3:0] gpio_sync_r;
   logic [7:0] tx_byte_r;
   logic tx_valid_r;
   logic cal_start_r;
   logic [6:0] gain_value_r;

   logic soft_rst;
   logic wr;
   logic last_wr;
   logic rd;
   logic [7:0] wd;
   logic [7:0] rdata;
   logic [7:0] rdata_rev;
   logic change_hit;

   // ***********************************
   // command parser
   // ***********************************
   // reset byte only counts in idle, inside a write it is plain data
   assign soft_rst = SOFT_RST | (state_r == PS_IDLE && RX_VALID && RX_BYTE == `CMD_RESET);
   assign wr = state_r == PS_WRITE && RX_VALID;
   assign last_wr = wr && cnt_r == 4'h0;
   assign rd = state_r == PS_READ && TX_REQ;
   assign wd = RX_BYTE;

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         state_r <= PS_IDLE;
         is_write_r <= 1'b0;
         addr_r <= 4'h0;
         cnt_r <= 4'h0;
      end else if (FRAME_END || soft_rst) begin
         state_r <= PS_IDLE;
      end else begin
         unique case (state_r)
            PS_IDLE: begin
               if (RX_VALID && (RX_BYTE[7:4] == `CMD_WRITE_HI || RX_BYTE[7:4] == `CMD_READ_HI)) begin
                  state_r <= PS_COUNT;
                  is_write_r <= RX_BYTE[7:4] == `CMD_WRITE_HI;
                  addr_r <= RX_BYTE[3:0];
               end
            end
            PS_COUNT: begin
               // high nibble of the count byte is ignored
               if (RX_VALID) begin
                  cnt_r <= RX_BYTE[3:0];
                  state_r <= is_write_r ? PS_WRITE : PS_READ;
               end
            end
            PS_WRITE, PS_READ: begin
               // 4-bit address wraps, holes read zero
               if (wr || rd) begin
                  addr_r <= addr_r + 4'h1;
                  cnt_r <= cnt_r - 4'h1;
                  if (cnt_r == 4'h0) begin
                     state_r <= PS_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // ***********************************
   // registers
   // ***********************************
   // id nibble and ready mirror have no storage, so writes to them drop
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         status_r <= `RST_STATUS_LOW;
      end else if (soft_rst) begin
         status_r <= `RST_STATUS_LOW;
      end else if (wr && addr_r == `REG_STATUS) begin
         status_r <= wd[`ST_ORDER:`ST_INPUT_BUFFER_ENABLE];
      end
   end

   // select codes kept raw, common input decode left to the mux
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         mux_r <= `RST_MUX;
      end else if (soft_rst) begin
         mux_r <= `RST_MUX;
      end else if (wr && addr_r == `REG_MUX) begin
         mux_r <= wd;
      end
   end

   // bit 7 reads zero, rate field lives in its own block
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         adc_control_low_r <= 5'(`RST_ADC_CONTROL);
      end else if (soft_rst) begin
         adc_control_low_r <= 5'(`RST_ADC_CONTROL);
      end else if (wr && addr_r == `REG_ADC_CONTROL) begin
         adc_control_low_r <= wd[`AD_SDCS_HI:0];
      end
   end

   // any code is stored, invalid rates are left to the host
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         data_rate_select_r <= `RST_DATA_RATE_SELECT;
      end else if (soft_rst) begin
         data_rate_select_r <= `RST_DATA_RATE_SELECT;
      end else if (wr && addr_r == `REG_DATA_RATE_SELECT) begin
         data_rate_select_r <= wd;
      end
   end

   // survives command and pattern resets
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         clk_rate_r <= 2'(`RST_ADC_CONTROL >> `AD_CLK_LO);
      end else if (wr && addr_r == `REG_ADC_CONTROL && !soft_rst) begin
         clk_rate_r <= wd[`AD_CLK_HI:`AD_CLK_LO];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 6; gi++) begin : g_cal
         always_ff @(posedge REF_CLK or negedge RST_B) begin
            if (!RST_B) begin
               cal_r[gi] <= `RST_CAL;
            end else if (soft_rst) begin
               cal_r[gi] <= `RST_CAL;
            end else if (wr && addr_r == 4'(gi + 5)) begin
               cal_r[gi] <= wd;
            end
         end
      end
      // output bit frozen while clock-out owns pin 0
      for (gi = 0; gi < 4; gi++) begin : g_gpio
         always_ff @(posedge REF_CLK or negedge RST_B) begin
            if (!RST_B) begin
               dir_r[gi] <= 1'(`RST_GPIO >> (gi + 4));
               dout_r[gi] <= 1'(`RST_GPIO >> gi);
            end else if (soft_rst) begin
               dir_r[gi] <= 1'(`RST_GPIO >> (gi + 4));
               dout_r[gi] <= 1'(`RST_GPIO >> gi);
            end else if (wr && addr_r == `REG_GPIO) begin
               dir_r[gi] <= wd[gi + 4];
               if (!wd[gi + 4] && !(gi == 0 && clk_rate_r != 2'h0)) begin
                  dout_r[gi] <= wd[gi];
               end
            end
         end
      end
   endgenerate

   // ***********************************
   // pin inputs and outputs
   // ***********************************
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         gpio_meta_r <= 4'h0;
         gpio_sync_r <= 4'h0;
         GPIO_O <= 4'h0;
         GPIO_OE <= 4'h0;
      end else begin
         // pins are asynchronous, two flops before any use
         gpio_meta_r <= GPIO_I;
         gpio_sync_r <= gpio_meta_r;
         GPIO_O <= dout_r;
         GPIO_OE <= ~dir_r;
      end
   end

   // ***********************************
   // read path
   // ***********************************
   always_comb begin
      rdata = 8'h00;
      unique case (addr_r)
         `REG_STATUS: rdata = {ID_CODE, status_r, CONV_READY_N};
         `REG_MUX: rdata = mux_r;
         `REG_ADC_CONTROL: rdata = {1'b0, clk_rate_r, adc_control_low_r};
         `REG_DATA_RATE_SELECT: rdata = data_rate_select_r;
         `REG_GPIO: rdata = {dir_r, gpio_sync_r};
         `REG_OFFSET_CAL_BYTE0, `REG_OFFSET_CAL_BYTE1, `REG_OFFSET_CAL_BYTE2, `REG_GAIN_CAL_BYTE0, `REG_GAIN_CAL_BYTE1, `REG_GAIN_CAL_BYTE2: begin
            rdata = cal_r[3'(addr_r - `REG_OFFSET_CAL_BYTE0)];
         end
         // 0Bh to 0Fh are holes
         default: rdata = 8'h00;
      endcase
   end

   // ***********************************
   // bit order
   // ***********************************
   // only bits inside the byte turn, byte order stays lowest address first
   generate
      for (gi = 0; gi < 8; gi++) begin : g_rev
         assign rdata_rev[gi] = rdata[7 - gi];
      end
   endgenerate

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         tx_byte_r <= 8'h00;
         tx_valid_r <= 1'b0;
      end else begin
         // a read cut by frame end or soft reset yields no byte
         tx_valid_r <= rd && !FRAME_END && !soft_rst;
         if (rd) begin
            tx_byte_r <= status_r[2] ? rdata_rev : rdata;
         end
      end
   end

   // ***********************************
   // auto calibration
   // ***********************************
   // compare against the live value so rewriting the same setting starts nothing
   assign change_hit = wr && ((addr_r == `REG_STATUS && wd[`ST_INPUT_BUFFER_ENABLE] != status_r[0])
      || (addr_r == `REG_ADC_CONTROL && wd[`AD_GAIN_HI:0] != adc_control_low_r[2:0])
      || (addr_r == `REG_DATA_RATE_SELECT && wd != data_rate_select_r));

   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         changed_r <= 1'b0;
         boot_r <= 1'b1;
         cal_start_r <= 1'b0;
      end else begin
         // boot and every reset calibrate whatever the enable says
         boot_r <= 1'b0;
         // change flag cleared per command, a cut command starts nothing
         if (state_r == PS_COUNT || soft_rst) begin
            changed_r <= 1'b0;
         end else if (change_hit) begin
            changed_r <= 1'b1;
         end
         // auto_cal_enable itself may be written by the same command, the value it holds when the last byte arrives is used
         cal_start_r <= boot_r || soft_rst
            || (last_wr && status_r[1] && (changed_r || change_hit));
      end
   end

   // ***********************************
   // outputs
   // ***********************************
   always_ff @(posedge REF_CLK or negedge RST_B) begin
      if (!RST_B) begin
         gain_value_r <= 7'h01;
      end else begin
         // top code saturates, the amplifier has no higher step
         unique case (adc_control_low_r[2:0])
            3'h0: gain_value_r <= 7'h01;
            3'h1: gain_value_r <= 7'h02;
            3'h2: gain_value_r <= 7'h04;
            3'h3: gain_value_r <= 7'h08;
            3'h4: gain_value_r <= 7'h10;
            3'h5: gain_value_r <= 7'h20;
            3'h6: gain_value_r <= 7'h40;
            3'h7: gain_value_r <= 7'h40;
         endcase
      end
   end

   assign TX_VALID = tx_valid_r;
   assign TX_BYTE = tx_byte_r;
   assign CAL_START = cal_start_r;
   // one driver for the whole struct, every field straight from a flop
   always_comb begin
      CFG.pos_channel = mux_r[6:4];
      CFG.pos_common = mux_r[7];
      CFG.neg_channel = mux_r[2:0];
      CFG.neg_common = mux_r[3];
      CFG.buffer_en = status_r[0];
      CFG.bit_order_lsb = status_r[2];
      CFG.auto_cal_enable = status_r[1];
      CFG.clk_rate = clk_rate_r;
      CFG.sensor_current = adc_control_low_r[4:3];
      CFG.gain_select = adc_control_low_r[2:0];
      CFG.gain_value = gain_value_r;
      CFG.rate_code = data_rate_select_r;
      // cal words keep the lowest address in the low byte
      CFG.offset_cal = {cal_r[2], cal_r[1], cal_r[0]};
      CFG.gain_cal = {cal_r[5], cal_r[4], cal_r[3]};
   end

endmodule : adc_config_register_bank

// File: shared/adc_regs_map.svh
// register offsets, field positions, reset values and command codes of the config bank
`ifndef ADC_REGS_MAP_SVH
`define ADC_REGS_MAP_SVH

// ***********************************
// register offsets
// ***********************************
`define REG_STATUS 4'h0
`define REG_MUX 4'h1
`define REG_ADC_CONTROL 4'h2
`define REG_DATA_RATE_SELECT 4'h3
`define REG_GPIO 4'h4
`define REG_OFFSET_CAL_BYTE0 4'h5
`define REG_OFFSET_CAL_BYTE1 4'h6
`define REG_OFFSET_CAL_BYTE2 4'h7
`define REG_GAIN_CAL_BYTE0 4'h8
`define REG_GAIN_CAL_BYTE1 4'h9
`define REG_GAIN_CAL_BYTE2 4'hA

// ***********************************
// field positions
// ***********************************
`define ST_ORDER 3
`define ST_AUTO_CAL_ENABLE 2
`define ST_INPUT_BUFFER_ENABLE 1
`define AD_CLK_HI 6
`define AD_CLK_LO 5
`define AD_SDCS_HI 4
`define AD_SDCS_LO 3
`define AD_GAIN_HI 2

// ***********************************
// reset values
// ***********************************
`define RST_STATUS_LOW 3'h0
`define RST_MUX 8'h01
`define RST_ADC_CONTROL 8'h20
`define RST_DATA_RATE_SELECT 8'hF0
`define RST_GPIO 8'hE0
`define RST_CAL 8'h00

// ***********************************
// command codes
// ***********************************
`define CMD_WRITE_HI 4'h5
`define CMD_READ_HI 4'h1
`define CMD_RESET 8'hFE

`endif

// File: shared/adc_regs_pkg.sv
// types shared by the config register bank
package adc_regs_pkg;

   typedef enum logic [1:0] {PS_IDLE, PS_COUNT, PS_WRITE, PS_READ} parse_e;

   typedef struct packed {
      logic [2:0] pos_channel;
      logic pos_common;
      logic [2:0] neg_channel;
      logic neg_common;
      logic buffer_en;
      logic bit_order_lsb;
      logic auto_cal_enable;
      logic [1:0] clk_rate;
      logic [1:0] sensor_current;
      logic [2:0] gain_select;
      logic [6:0] gain_value;
      logic [7:0] rate_code;
      logic [23:0] offset_cal;
      logic [23:0] gain_cal;
   } cfg_s;

endpackage : adc_regs_pkg

// File: test/adc_bank_asserts.sv
// concurrent checks on the ports of the config register bank
`timescale 1ns/100ps
module adc_bank_asserts
   import adc_regs_pkg::*;
(
   input wire logic REF_CLK,
   input wire logic RST_B,
   input wire logic RX_VALID,
   input wire logic FRAME_END,
   input wire logic TX_REQ,
   input wire logic SOFT_RST,
   input wire logic TX_VALID,
   input wire adc_regs_pkg::cfg_s CFG,
   input wire logic CAL_START
);
   logic [6:0] gain_exp;
   // top code repeats the largest gain
   assign gain_exp = (CFG.gain_select == 3'h7) ? 7'h40 : 7'(7'h01 << CFG.gain_select);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_B);
   // ***************
   // properties
   // ***************
   AST_TX_CAUSE: assert property (TX_VALID |-> $past(TX_REQ))
      else $error("read byte without a request");
   AST_IDLE_TXREQ: assert property (FRAME_END ##1 (TX_REQ && !RX_VALID) |=> !TX_VALID)
      else $error("read byte after frame end");
   AST_SOFT_KEEP: assert property (SOFT_RST |=> $stable(CFG.clk_rate))
      else $error("clock-out rate lost on soft reset");
   AST_SOFT_DEF: assert property (SOFT_RST |=> CFG.rate_code == 8'hF0 && !CFG.buffer_en
      && CFG.gain_select == 3'h0 && CFG.neg_channel == 3'h1)
      else $error("soft reset defaults wrong");
   AST_SOFT_CAL: assert property (SOFT_RST |-> ##[1:2] CAL_START)
      else $error("no calibration after soft reset");
   AST_CAL_PULSE: assert property (CAL_START |=> !CAL_START)
      else $error("calibration start longer than one cycle");
   AST_GAIN_MAP: assert property ($stable(CFG.gain_select)
      && CFG.gain_select == $past(CFG.gain_select, 2) |-> CFG.gain_value == gain_exp)
      else $error("gain value does not match gain code");
   AST_RESET_VALUES: assert property ($rose(RST_B) |-> CFG.rate_code == 8'hF0
      && CFG.clk_rate == 2'h1 && CFG.sensor_current == 2'h0 && !CFG.pos_common)
      else $error("reset values wrong");
   cover property (CAL_START);
   cover property (SOFT_RST);
   cover property (TX_VALID && CFG.bit_order_lsb);
endmodule : adc_bank_asserts

bind adc_config_register_bank adc_bank_asserts adc_bank_asserts_inst (.REF_CLK(REF_CLK),
   .RST_B(RST_B), .RX_VALID(RX_VALID), .FRAME_END(FRAME_END), .TX_REQ(TX_REQ),
   .SOFT_RST(SOFT_RST), .TX_VALID(TX_VALID), .CFG(CFG), .CAL_START(CAL_START));

// File: test/host_model.sv
// host controller model issuing register commands to the bank
`timescale 1ns/100ps
module host_model (
   input wire logic REF_CLK,
   output logic RX_VALID,
   output logic [7:0] RX_BYTE,
   output logic FRAME_END,
   output logic TX_REQ,
   output logic SOFT_RST
);
   initial begin
      RX_VALID = 1'b0;
      RX_BYTE = 8'hA5;
      {SOFT_RST, FRAME_END, TX_REQ} = 3'b000;
   end
   // whole bytes, msb first; idle byte line shows the inverse, never a stale copy
   task automatic put(input logic [7:0] b);
      @(posedge REF_CLK);
      #1 RX_VALID = 1'b1;
      RX_BYTE = b;
      @(posedge REF_CLK);
      #1 RX_VALID = 1'b0;
      RX_BYTE = ~b;
   endtask : put
   // only register commands, never continuous read
   task automatic cmd(input logic [3:0] op, input logic [3:0] a, input int n);
      put({op, a});
      put({4'h0, 4'(n - 1)});
   endtask : cmd
   task automatic pulse(input logic [2:0] s);
      @(posedge REF_CLK);
      #1 {SOFT_RST, FRAME_END, TX_REQ} = s;
      @(posedge REF_CLK);
      #1 {SOFT_RST, FRAME_END, TX_REQ} = 3'b000;
   endtask : pulse
   // frame end, then a stray request that must be ignored
   task automatic abort();
      @(posedge REF_CLK);
      #1 FRAME_END = 1'b1;
      @(posedge REF_CLK);
      #1 FRAME_END = 1'b0;
      TX_REQ = 1'b1;
      @(posedge REF_CLK);
      #1 TX_REQ = 1'b0;
   endtask : abort
endmodule : host_model

// File: test/tb_top.sv
// self-checking bench for the config register bank
`timescale 1ns/100ps
module tb_top;
   import adc_regs_pkg::*;
   localparam logic [3:0] ID_TB = 4'h9; // arbitrary value
   logic REF_CLK, RST_B, CONV_READY_N, RX_VALID, FRAME_END, TX_REQ, SOFT_RST, TX_VALID, CAL_START;
   logic [7:0] RX_BYTE, TX_BYTE, r;
   logic [3:0] ext, GPIO_I, GPIO_O, GPIO_OE;
   logic [31:0] seed = 32'h2590642E;
   logic [7:0] expq[$], q[$];
   logic [7:0] v;
   cfg_s CFG;
   int fails = 0, n_checks = 0, n_cal = 0, c0;
   // pad level: driven pins read back what the bank drives
   assign GPIO_I = (GPIO_OE & GPIO_O) | (~GPIO_OE & ext);
   adc_config_register_bank #(.ID_CODE(ID_TB)) adc_config_register_bank_inst (.REF_CLK(REF_CLK),
      .RST_B(RST_B), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE), .FRAME_END(FRAME_END),
      .TX_REQ(TX_REQ), .SOFT_RST(SOFT_RST), .CONV_READY_N(CONV_READY_N), .GPIO_I(GPIO_I),
      .TX_VALID(TX_VALID), .TX_BYTE(TX_BYTE), .CFG(CFG), .CAL_START(CAL_START),
      .GPIO_O(GPIO_O), .GPIO_OE(GPIO_OE));
   host_model host_model_inst (.REF_CLK(REF_CLK), .RX_VALID(RX_VALID), .RX_BYTE(RX_BYTE),
      .FRAME_END(FRAME_END), .TX_REQ(TX_REQ), .SOFT_RST(SOFT_RST));
   initial begin
      REF_CLK = 1'b0;
      forever #2 REF_CLK = ~REF_CLK;
   end
   // ***************
   // helpers
   // ***************
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   function automatic logic [7:0] rev(input logic [7:0] b);
      for (int i = 0; i < 8; i++) rev[i] = b[7 - i];
   endfunction : rev
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   task automatic wr(input logic [3:0] a, input logic [7:0] d[$]);
      host_model_inst.cmd(4'h5, a, d.size());
      foreach (d[i]) host_model_inst.put(d[i]);
      host_model_inst.abort();
      repeat (3) @(posedge REF_CLK);
   endtask : wr
   task automatic rd(input logic [3:0] a, input int n);
      host_model_inst.cmd(4'h1, a, n);
      repeat (n) host_model_inst.pulse(3'b001);
      host_model_inst.abort();
      repeat (3) @(posedge REF_CLK);
   endtask : rd
   // ***************
   // watchers
   // ***************
   always @(negedge REF_CLK) begin
      if (CAL_START === 1'b1) n_cal++;
      if (TX_VALID === 1'b1) begin
         if (expq.size() == 0) chk("tx_extra", 0, 1);
         else chk("tx_byte", expq.pop_front(), TX_BYTE);
      end
   end
   initial begin
      repeat (20000) @(posedge REF_CLK);
      fails++;
      results();
   end
   // ***************
   // main sequence
   // ***************
   initial begin
      RST_B = 1'b0;
      CONV_READY_N = 1'b1;
      ext = 4'hA;
      repeat (3) @(posedge REF_CLK);
      #1 RST_B = 1'b1;
      repeat (6) @(posedge REF_CLK);
      chk("gpio_reset", {4'h0, 4'h1}, {GPIO_O, GPIO_OE});
      q = '{{ID_TB, 4'h1}, 8'h01, 8'h20, 8'hF0, 8'hEA, 0, 0, 0, 0, 0, 0, 0};
      foreach (q[i]) expq.push_back(q[i]);
      rd(4'h0, 12);
      #1 CONV_READY_N = 1'b0;
      expq.push_back({ID_TB, 4'h0});
      rd(4'h0, 1);
      c0 = n_cal;
      wr(4'h0, '{8'hFF});
      chk("status_cfg", 3'b111, {CFG.bit_order_lsb, CFG.auto_cal_enable, CFG.buffer_en});
      chk("cal_count", c0, n_cal);
      expq.push_back(rev({ID_TB, 4'hE}));
      rd(4'h0, 1);
      wr(4'h3, '{8'hF0});
      chk("cal_count", c0, n_cal);
      wr(4'h3, '{8'h82});
      chk("cal_count", c0 + 1, n_cal);
      chk("rate", 8'h82, CFG.rate_code);
      for (int i = 0; i < 8; i++) begin
         v = {1'b1, i[1:0], i[1:0], i[2:0]};
         c0 = n_cal;
         wr(4'h2, '{v});
         chk("clk_rate", i[1:0], CFG.clk_rate);
         chk("sensor", i[1:0], CFG.sensor_current);
         chk("gain", (i == 7) ? 64 : (1 << i), CFG.gain_value);
         chk("cal_count", c0 + (i != 0), n_cal);
         expq.push_back(rev({1'b0, v[6:0]}));
         rd(4'h2, 1);
      end
      c0 = n_cal;
      host_model_inst.pulse(3'b100);
      repeat (4) @(posedge REF_CLK);
      chk("clk_keep", 2'h3, CFG.clk_rate);
      chk("soft_def", {8'hF0, 3'h0, 2'h0}, {CFG.rate_code, CFG.gain_select, CFG.bit_order_lsb, CFG.buffer_en});
      chk("cal_count", c0 + 1, n_cal);
      expq.push_back(8'h60);
      rd(4'h2, 1);
      wr(4'h4, '{8'h0F});
      chk("gpio_out", 4'hE, GPIO_O);
      chk("gpio_oe", 4'hF, GPIO_OE);
      expq.push_back(8'h0E);
      rd(4'h4, 1);
      repeat (4) begin
         seed = xs(seed);
         r = seed[7:0];
         wr(4'h1, '{r});
         chk("pos", {r[7], r[7] ? 3'h0 : r[6:4]}, {CFG.pos_common, CFG.pos_common ? 3'h0 : CFG.pos_channel});
         chk("neg", {r[3], r[3] ? 3'h0 : r[2:0]}, {CFG.neg_common, CFG.neg_common ? 3'h0 : CFG.neg_channel});
         expq.push_back(r);
         rd(4'h1, 1);
      end
      q = {};
      repeat (6) begin
         seed = xs(seed);
         q.push_back(seed[7:0]);
      end
      wr(4'h5, q);
      chk("offset_cal", {q[2], q[1], q[0]}, CFG.offset_cal);
      chk("gain_cal", {q[5], q[4], q[3]}, CFG.gain_cal);
      foreach (q[i]) expq.push_back(q[i]);
      rd(4'h5, 6);
      #1 RST_B = 1'b0;
      repeat (2) @(posedge REF_CLK);
      #1 RST_B = 1'b1;
      repeat (4) @(posedge REF_CLK);
      chk("clk_pin_reset", 2'h1, CFG.clk_rate);
      chk("tx_left", 0, expq.size());
      results();
   end
endmodule : tb_top
